// ===== rtl/mcb_host.sv
`timescale 1ns/1ps
module mcb_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,       // Host clock
  input  wire logic         resetn,    // Asynchronous reset, active low
  input  wire logic         in_valid,  // Write data offered
  output logic              in_ready,  // Room for a word
  input  wire logic [W-1:0] in_data,   // Write data
  output logic              out_valid, // Word available
  input  wire logic         out_ready, // Word taken
  output logic [W-1:0]      out_data   // Head word
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("mcb_fifo: depth must be a power of two");
    end
  endgenerate

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          in_ready;
    logic          out_valid;
  } mcb_fifo_st_t;

  logic [W-1:0] mem [DEPTH];
  mcb_fifo_st_t f_r;
  mcb_fifo_st_t f_nxt;
  logic         push;
  logic         pop;

  always_comb begin
    f_nxt           = f_r;
    push            = in_valid & f_r.in_ready;
    pop             = out_ready & f_r.out_valid;
    f_nxt.wp        = f_r.wp + AW'(push);
    f_nxt.rp        = f_r.rp + AW'(pop);
    f_nxt.cnt       = f_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    f_nxt.in_ready  = (f_nxt.cnt != (AW+1)'(DEPTH));
    f_nxt.out_valid = (f_nxt.cnt != '0);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      f_r <= '{in_ready: 1'b1, default: '0};
    end else begin
      f_r <= f_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[f_r.wp] <= in_data;
    end
  end

  assign in_ready  = f_r.in_ready;
  assign out_valid = f_r.out_valid;
  assign out_data  = mem[f_r.rp];

endmodule : mcb_fifo

module mcb_host #(
  parameter int BLOCK_BYTES    = mcb_pkg::BLOCK_BYTES,
  parameter int WR_TIMEOUT_CYC = mcb_pkg::WR_TIMEOUT_CYC,
  parameter int FIFO_DEPTH     = 8
) (
  input  wire logic       clk,         // Host clock
  input  wire logic       resetn,      // Asynchronous reset, active low
  input  wire logic [1:0] bus_mode,    // Serial, native 1-bit or native 4-bit
  input  wire logic       slow_clk,    // Initialization link rate
  input  wire logic       cmd_valid,   // Command request
  input  wire logic [1:0] cmd_kind,    // Single, multi or stop
  output logic            cmd_ready,   // Ready for a command
  input  wire logic       wr_valid,    // Write byte offered
  input  wire logic [7:0] wr_data,     // Write byte
  output logic            wr_ready,    // Buffer has room
  input  wire logic [31:0] read_access_time_field,    // Access time field in clocks
  input  wire logic [7:0] access_clock_cycles_field,  // Access clock cycles field
  input  wire logic [5:0] r2w_mult,    // Write speed factor
  output logic            done,        // Command finished
  output logic            timeout_err, // Busy wait expired
  mcb_if.host             link         // Host end of the bus
);
  localparam int NW = $clog2(BLOCK_BYTES + 2);

  generate
    if (WR_TIMEOUT_CYC < 1 || BLOCK_BYTES < 1) begin : g_chk
      $error("mcb_host: bad timeout or block size");
    end
  endgenerate

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_XFER = 4'b0010,
    H_WIN  = 4'b0100,
    H_BUSY = 4'b1000
  } mcb_hst_t;

  typedef struct packed {
    logic          bs1;
    logic          bs2;
    logic [5:0]    hcnt;
    logic          sclk;
    logic          cs_n;
    logic          sdi;
    logic [3:0]    dat_o;
    logic [3:0]    dat_oe;
    logic          cmd_o;
    logic          cmd_oe;
    mcb_hst_t      st;
    logic          multi;
    logic          stop;
    logic [7:0]    sh;
    logic [2:0]    bits;
    logic [NW-1:0] cnt;
    logic [3:0]    win;
    logic [31:0]   tmo;
    logic          cmd_ready;
    logic          done;
    logic          err;
  } mcb_host_st_t;

  mcb_host_st_t h_r;
  mcb_host_st_t h_nxt;
  logic         f_valid;
  logic         f_pop;
  logic [7:0]   f_data;
  logic         spi;
  logic         nat4;
  logic         wide;
  logic         stall;
  logic         fall;
  logic         finish;
  logic [NW-1:0] end_cnt;
  logic [7:0]   cur;
  logic [31:0]  calc;
  logic [31:0]  limit;

  mcb_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  always_comb begin
    h_nxt      = h_r;
    h_nxt.done = 1'b0;
    h_nxt.err  = 1'b0;
    spi        = (bus_mode == mcb_pkg::MODE_SPI);
    nat4       = (bus_mode == mcb_pkg::MODE_NAT4);
    // Stop token goes one bit per fall, on the command line in native modes and on sdi in serial mode
    wide       = nat4 & ~h_r.stop;
    h_nxt.bs1  = spi ? link.sdo : link.dat[0];
    h_nxt.bs2  = h_r.bs1;
    calc       = mcb_pkg::mcb_wr_timeout(read_access_time_field, access_clock_cycles_field,
                                         r2w_mult);
    limit      = (calc > 32'(WR_TIMEOUT_CYC)) ? calc : 32'(WR_TIMEOUT_CYC);
    end_cnt    = h_r.stop ? NW'(1) : NW'(BLOCK_BYTES + 1);
    stall      = (h_r.st == H_XFER) && h_r.bits == 3'h0 && h_r.cnt != '0
               && h_r.cnt != end_cnt && !f_valid;
    fall       = (h_r.hcnt == 6'h00) & h_r.sclk & ~stall;
    f_pop      = fall && (h_r.st == H_XFER) && h_r.bits == 3'h0 && h_r.cnt != '0
               && h_r.cnt != end_cnt;
    finish     = 1'b0;
    cur        = 8'hFF;
    // ************
    // Link clock divider, paused while the buffer runs dry
    // ************
    if (h_r.hcnt != 6'h00) begin
      h_nxt.hcnt = h_r.hcnt - 6'h01;
    end else if (!(h_r.sclk && stall)) begin
      h_nxt.sclk = ~h_r.sclk;
      h_nxt.hcnt = slow_clk ? 6'(mcb_pkg::INIT_HALF - 1) : 6'(mcb_pkg::FAST_HALF - 1);
    end
    case (h_r.st)
      H_IDLE: begin
        if (cmd_valid && h_r.cmd_ready) begin
          h_nxt.cnt  = '0;
          h_nxt.bits = 3'h0;
          if (cmd_kind == mcb_pkg::MCB_STOP) begin
            if (h_r.multi) begin
              h_nxt.stop      = 1'b1;
              h_nxt.st        = H_XFER;
              h_nxt.cmd_ready = 1'b0;
            end else begin
              h_nxt.done = 1'b1;
            end
          end else begin
            h_nxt.stop      = 1'b0;
            h_nxt.multi     = (cmd_kind == mcb_pkg::MCB_MULTI);
            h_nxt.cs_n      = 1'b0;
            h_nxt.st        = H_XFER;
            h_nxt.cmd_ready = 1'b0;
          end
        end
      end
      H_XFER: begin
        if (fall) begin
          if (h_r.bits == 3'h0 && h_r.cnt == end_cnt) begin
            h_nxt.sdi    = 1'b1;
            h_nxt.dat_oe = 4'h0;
            h_nxt.cmd_oe = 1'b0;
            h_nxt.win    = 4'h0;
            h_nxt.st     = H_WIN;
          end else begin
            if (h_r.bits != 3'h0) begin
              cur = h_r.sh;
            end else if (h_r.cnt != '0) begin
              cur = f_data;
            end else if (h_r.stop) begin
              cur = mcb_pkg::TOK_STOP;
            end else begin
              cur = h_r.multi ? mcb_pkg::TOK_MULTI : mcb_pkg::TOK_SINGLE;
            end
            if (h_r.bits == 3'h0) begin
              h_nxt.cnt = h_r.cnt + 1'b1;
            end
            h_nxt.sdi    = cur[7];
            h_nxt.dat_o  = wide ? cur[7:4] : {3'b111, cur[7]};
            h_nxt.cmd_o  = cur[7];
            h_nxt.cmd_oe = ~spi & h_r.stop;
            h_nxt.dat_oe = (spi || h_r.stop) ? 4'h0 : (nat4 ? 4'hF : 4'h1);
            h_nxt.sh     = wide ? {cur[3:0], 4'hF} : {cur[6:0], 1'b1};
            h_nxt.bits   = h_r.bits + (wide ? 3'h4 : 3'h1);
          end
        end
      end
      H_WIN: begin
        if (!h_r.bs2) begin
          h_nxt.tmo = '0;
          h_nxt.st  = H_BUSY;
        end else if (fall) begin
          h_nxt.win = h_r.win + 4'h1;
          if (h_r.win == 4'(mcb_pkg::BUSY_WIN_MAX - 1)) begin
            finish = 1'b1;
          end
        end
      end
      H_BUSY: begin
        h_nxt.tmo = h_r.tmo + 32'h1;
        if (h_r.bs2) begin
          finish = 1'b1;
        end else if (h_r.tmo >= limit) begin
          h_nxt.err   = 1'b1;
          h_nxt.multi = 1'b0;
          finish      = 1'b1;
        end
      end
      default: begin
        h_nxt.st = H_IDLE;
      end
    endcase
    if (finish) begin
      h_nxt.done      = 1'b1;
      h_nxt.cmd_ready = 1'b1;
      h_nxt.st        = H_IDLE;
      if (h_r.stop || !h_nxt.multi) begin
        h_nxt.multi = 1'b0;
        h_nxt.cs_n  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      h_r <= '{bs1: 1'b1, bs2: 1'b1, cs_n: 1'b1, sdi: 1'b1, dat_o: 4'hF, cmd_o: 1'b1,
               st: H_IDLE, sh: 8'hFF, cmd_ready: 1'b1, default: '0};
    end else begin
      h_r <= h_nxt;
    end
  end

  assign cmd_ready     = h_r.cmd_ready;
  assign done          = h_r.done;
  assign timeout_err   = h_r.err;
  assign link.sclk     = h_r.sclk;
  assign link.cs_n     = h_r.cs_n;
  assign link.sdi      = h_r.sdi;
  assign link.dat_h    = h_r.dat_o;
  assign link.dat_h_oe = h_r.dat_oe;
  assign link.cmd_h    = h_r.cmd_o;
  assign link.cmd_h_oe = h_r.cmd_oe;

endmodule : mcb_host

// ===== rtl/mcb_pkg.sv
package mcb_pkg;

  // ************
  // Transfer shape
  // ************
  localparam int         BLOCK_BYTES  = 512;
  localparam int         NUM_BUFFERS  = 2;
  localparam int         PROG_CYCLES  = 64;
  localparam logic [7:0] TOK_SINGLE   = 8'hFE;
  localparam logic [7:0] TOK_MULTI    = 8'hFC;
  localparam logic [7:0] TOK_STOP     = 8'hFD;
  localparam logic [1:0] MODE_SPI     = 2'h0;
  localparam logic [1:0] MODE_NAT1    = 2'h1;
  localparam logic [1:0] MODE_NAT4    = 2'h2;

  // ************
  // Clocks and timeouts
  // ************
  localparam int CLK_HZ           = 25_000_000;
  localparam int INIT_SCLK_HZ     = 400_000;
  localparam int CARD_SCLK_MAX_HZ   = 25_000_000;
  localparam int LEGACY_SCLK_MAX_HZ = 20_000_000;
  // Least half period rounds up so the link never runs above the limit
  localparam int INIT_HALF        = (CLK_HZ + 2 * INIT_SCLK_HZ - 1) / (2 * INIT_SCLK_HZ);
  localparam int FAST_HALF        = (CLK_HZ + 2 * LEGACY_SCLK_MAX_HZ - 1) / (2 * LEGACY_SCLK_MAX_HZ);
  localparam int RD_TIMEOUT_MS    = 100;
  localparam int WR_TIMEOUT_MS    = 250;
  localparam int RD_TIMEOUT_CYC   = RD_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int WR_TIMEOUT_CYC   = WR_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int BUSY_WIN_MAX     = 8;
  localparam int NAC_UNIT_CLKS    = 100;

  typedef enum logic [1:0] {
    MCB_SINGLE = 2'h0,
    MCB_MULTI  = 2'h1,
    MCB_STOP   = 2'h2
  } mcb_cmd_t;

  // Write timeout in clocks from the card timing fields
  function automatic logic [31:0] mcb_wr_timeout(input logic [31:0] access_clks,
                                                 input logic [7:0]  cycle_units,
                                                 input logic [5:0]  r2w);
    logic [31:0] rd;
    rd = access_clks + 32'(cycle_units) * 32'(NAC_UNIT_CLKS);
    return 32'(rd * 32'(r2w));
  endfunction : mcb_wr_timeout

endpackage : mcb_pkg

// ===== rtl/mcb_if.sv
`timescale 1ns/1ps
interface mcb_if;
  logic       sclk;
  logic       cs_n;
  logic       sdi;
  logic       sdo_c;
  logic       sdo_c_oe;
  logic       cmd_h;
  logic       cmd_h_oe;
  logic       cmd_c;
  logic       cmd_c_oe;
  logic [3:0] dat_h;
  logic [3:0] dat_h_oe;
  logic [3:0] dat_c;
  logic [3:0] dat_c_oe;
  logic       sdo;
  logic       cmd;
  logic [3:0] dat;

  // ************
  // Pulled-up wires
  // ************
  assign sdo = sdo_c | ~sdo_c_oe;
  assign cmd = (cmd_h | ~cmd_h_oe) & (cmd_c | ~cmd_c_oe);
  assign dat = (dat_h | ~dat_h_oe) & (dat_c | ~dat_c_oe);

  modport card (input sclk, cs_n, sdi, cmd, dat,
                output sdo_c, sdo_c_oe, cmd_c, cmd_c_oe, dat_c, dat_c_oe);
  modport host (input sdo, cmd, dat,
                output sclk, cs_n, sdi, cmd_h, cmd_h_oe, dat_h, dat_h_oe);
endinterface : mcb_if

// ===== rtl/mcb_card.sv
`timescale 1ns/1ps
// Functional notes
// - Busy may start within window after stop
// - Busy output follows chip select by one clock
// - Host clock programmable, slow during open-drain
// - Card goes push-pull after initialization in serial mode only
// - Host write timeout never below card maximum
// - Host derives write timeout from card timing fields
// - Host keeps link clock within card maximum
// - Serial bus with separate in, out, clock, select
// - Native one-bit and four-bit bidirectional modes
// - Single block per command, multi until stop
// - Single write holds data low while programming
// - Multi write busy only when buffers full
// - Host buffers data for long multi transfers
module mcb_card #(
  parameter int BLOCK_BYTES = mcb_pkg::BLOCK_BYTES,
  parameter int NBUF        = mcb_pkg::NUM_BUFFERS,
  parameter int PROG_CYCLES = mcb_pkg::PROG_CYCLES
) (
  input  wire logic       clk,        // Card core clock
  input  wire logic       resetn,     // Asynchronous reset, active low
  input  wire logic [1:0] bus_mode,   // Serial, native 1-bit or native 4-bit
  input  wire logic       init_done,  // Initialization finished
  mcb_if.card             link,       // Card end of the bus
  output logic            prog_valid, // Byte moved to the flash array
  output logic [7:0]      prog_data,  // Byte being programmed
  output logic            prog_last,  // Last byte of a block
  output logic            card_busy   // Some block buffer occupied
);
  localparam int CW = $clog2(BLOCK_BYTES);
  localparam int BW = $clog2(NBUF);
  localparam int PW = $clog2(PROG_CYCLES + 1);

  generate
    if (NBUF < 2 || (1 << BW) != NBUF || (1 << CW) != BLOCK_BYTES || PROG_CYCLES < 1) begin : g_chk
      $error("mcb_card: buffers and block size must be powers of two");
    end
  endgenerate

  typedef enum logic [2:0] {
    L_HUNT = 3'b001,
    L_RECV = 3'b010,
    L_HOLD = 3'b100
  } mcb_lst_t;

  typedef enum logic [2:0] {
    P_IDLE = 3'b001,
    P_MOVE = 3'b010,
    P_PROG = 3'b100
  } mcb_pst_t;

  typedef struct packed {
    logic [1:0]      mode_s1;
    logic [1:0]      mode_s2;
    logic            pp_s1;
    logic            pp_s2;
    logic [NBUF-1:0] done_s1;
    logic [NBUF-1:0] done_s2;
    mcb_lst_t        st;
    logic            multi;
    logic [7:0]      sh;
    logic [7:0]      csh;
    logic [2:0]      bits;
    logic [CW-1:0]   cnt;
    logic [BW-1:0]   wbuf;
    logic [NBUF-1:0] full_t;
    logic            sdo;
    logic            sdo_oe;
    logic            dat0;
    logic            dat0_oe;
  } mcb_lnk_t;

  typedef struct packed {
    logic [NBUF-1:0] full_s1;
    logic [NBUF-1:0] full_s2;
    logic [NBUF-1:0] done_t;
    logic            pp;
    mcb_pst_t        st;
    logic [BW-1:0]   rbuf;
    logic [CW-1:0]   rcnt;
    logic [PW-1:0]   pcnt;
    logic            prog_valid;
    logic [7:0]      prog_data;
    logic            prog_last;
    logic            busy;
  } mcb_core_t;

  logic [7:0]       mem [NBUF*BLOCK_BYTES];
  mcb_lnk_t         l_r;
  mcb_lnk_t         l_nxt;
  mcb_core_t        c_r;
  mcb_core_t        c_nxt;
  logic             mem_we;
  logic [BW+CW-1:0] mem_wa;
  logic [7:0]       sh_in;
  logic [7:0]       csh_in;
  logic [2:0]       bits_n;
  logic [NBUF-1:0]  occ;
  logic             spi;
  logic             nat4;
  logic             sel;
  logic             busy;

  // ************
  // Link side, on the link clock
  // ************
  always_comb begin
    l_nxt         = l_r;
    l_nxt.mode_s1 = bus_mode;
    l_nxt.mode_s2 = l_r.mode_s1;
    l_nxt.pp_s1   = c_r.pp;
    l_nxt.pp_s2   = l_r.pp_s1;
    l_nxt.done_s1 = c_r.done_t;
    l_nxt.done_s2 = l_r.done_s1;
    spi           = (l_r.mode_s2 == mcb_pkg::MODE_SPI);
    nat4          = (l_r.mode_s2 == mcb_pkg::MODE_NAT4);
    sel           = spi ? ~link.cs_n : 1'b1;
    sh_in         = nat4 ? {l_r.sh[3:0], link.dat}
                         : {l_r.sh[6:0], spi ? link.sdi : link.dat[0]};
    csh_in        = {l_r.csh[6:0], link.cmd};
    bits_n        = l_r.bits + (nat4 ? 3'h4 : 3'h1);
    occ           = l_r.full_t ^ l_r.done_s2;
    mem_we        = 1'b0;
    mem_wa        = {l_r.wbuf, l_r.cnt};
    l_nxt.csh     = csh_in;
    if (sel) begin
      l_nxt.sh = sh_in;
    end
    case (l_r.st)
      L_HUNT: begin
        l_nxt.bits = 3'h0;
        l_nxt.cnt  = '0;
        if (sel && !(&occ) && (sh_in == mcb_pkg::TOK_SINGLE || sh_in == mcb_pkg::TOK_MULTI)) begin
          l_nxt.st    = L_RECV;
          l_nxt.multi = (sh_in == mcb_pkg::TOK_MULTI);
        end else if (spi ? (sel && sh_in == mcb_pkg::TOK_STOP)
                         : (csh_in == mcb_pkg::TOK_STOP)) begin
          l_nxt.multi = 1'b0;
        end
      end
      L_RECV: begin
        l_nxt.bits = bits_n;
        if (bits_n == 3'h0) begin
          mem_we    = 1'b1;
          l_nxt.cnt = l_r.cnt + 1'b1;
          if (l_r.cnt == CW'(BLOCK_BYTES - 1)) begin
            l_nxt.full_t[l_r.wbuf] = ~l_r.full_t[l_r.wbuf];
            l_nxt.wbuf             = l_r.wbuf + 1'b1;
            l_nxt.st               = l_r.multi ? L_HUNT : L_HOLD;
          end
        end
      end
      L_HOLD: begin
        if (occ == '0) begin
          l_nxt.st = L_HUNT;
        end
      end
      default: begin
        l_nxt.st = L_HUNT;
      end
    endcase
    // Busy: single block programming, all buffers taken, or draining after stop
    busy = (l_r.st == L_HOLD) | (&occ)
         | (l_r.st == L_HUNT && !l_r.multi && |occ);
    l_nxt.sdo     = ~busy;
    l_nxt.sdo_oe  = spi & sel & (l_r.pp_s2 | busy);
    l_nxt.dat0    = ~busy;
    l_nxt.dat0_oe = ~spi & busy & (l_r.st != L_RECV);
  end

  always_ff @(posedge link.sclk or negedge resetn) begin
    if (!resetn) begin
      l_r <= '{st: L_HUNT, sh: 8'hFF, csh: 8'hFF, sdo: 1'b1, dat0: 1'b1, default: '0};
    end else begin
      l_r <= l_nxt;
    end
  end

  always_ff @(posedge link.sclk) begin
    if (mem_we) begin
      mem[mem_wa] <= sh_in;
    end
  end

  assign link.sdo_c    = l_r.sdo;
  assign link.sdo_c_oe = l_r.sdo_oe;
  assign link.dat_c    = {3'b111, l_r.dat0};
  assign link.dat_c_oe = {3'b000, l_r.dat0_oe};
  assign link.cmd_c    = 1'b1;
  assign link.cmd_c_oe = 1'b0;

  // ************
  // Programming side, on the core clock
  // ************
  always_comb begin
    c_nxt            = c_r;
    c_nxt.full_s1    = l_r.full_t;
    c_nxt.full_s2    = c_r.full_s1;
    c_nxt.pp         = init_done;
    c_nxt.prog_valid = 1'b0;
    c_nxt.prog_last  = 1'b0;
    c_nxt.busy       = |(c_r.full_s2 ^ c_r.done_t);
    case (c_r.st)
      P_IDLE: begin
        if (c_r.full_s2[c_r.rbuf] != c_r.done_t[c_r.rbuf]) begin
          c_nxt.st   = P_MOVE;
          c_nxt.rcnt = '0;
        end
      end
      P_MOVE: begin
        c_nxt.prog_valid = 1'b1;
        c_nxt.prog_data  = mem[{c_r.rbuf, c_r.rcnt}];
        c_nxt.rcnt       = c_r.rcnt + 1'b1;
        if (c_r.rcnt == CW'(BLOCK_BYTES - 1)) begin
          c_nxt.prog_last = 1'b1;
          c_nxt.st        = P_PROG;
          c_nxt.pcnt      = '0;
        end
      end
      P_PROG: begin
        c_nxt.pcnt = c_r.pcnt + 1'b1;
        if (c_r.pcnt == PW'(PROG_CYCLES - 1)) begin
          c_nxt.done_t[c_r.rbuf] = ~c_r.done_t[c_r.rbuf];
          c_nxt.rbuf             = c_r.rbuf + 1'b1;
          c_nxt.st               = P_IDLE;
        end
      end
      default: begin
        c_nxt.st = P_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      c_r <= '{st: P_IDLE, default: '0};
    end else begin
      c_r <= c_nxt;
    end
  end

  assign prog_valid = c_r.prog_valid;
  assign prog_data  = c_r.prog_data;
  assign prog_last  = c_r.prog_last;
  assign card_busy  = c_r.busy;

endmodule : mcb_card

// ===== bench/mcb_chk.sv
`timescale 1ns/1ps
module mcb_chk (
  input  wire logic       clk,      // Host clock
  input  wire logic       resetn,   // Reset, active low
  input  wire logic       sclk,     // Link clock
  input  wire logic       cs_n,     // Select
  input  wire logic       sdo,      // Serial out wire
  input  wire logic       sdo_c_oe, // Card serial enable
  input  wire logic       cmd_c_oe, // Card command enable
  input  wire logic [3:0] dat_h_oe, // Host data enables
  input  wire logic [3:0] dat_c,    // Card data drive
  input  wire logic [3:0] dat_c_oe  // Card data enables
);
  logic dbusy;
  assign dbusy = dat_c_oe[0] & ~dat_c[0];
  // ************
  // Link checks
  // ************
  chk_sdo_release: assert property (@(posedge sclk) disable iff (!resetn)
    $rose(cs_n) |=> !sdo_c_oe) else $error("sdo held after deselect");
  chk_sdo_desel: assert property (@(posedge sclk) disable iff (!resetn)
    cs_n [*3] |-> !sdo_c_oe) else $error("sdo driven while deselected");
  chk_cmd_card_off: assert property (@(posedge clk) disable iff (!resetn)
    !cmd_c_oe) else $error("card drives command line");
  chk_dat_upper_off: assert property (@(posedge clk) disable iff (!resetn)
    dat_c_oe[3:1] == 3'h0) else $error("card drives upper data lines");
  chk_busy_holds: assert property (@(posedge clk) disable iff (!resetn)
    $fell(sdo) && !cs_n && sdo_c_oe |=> !sdo [*4]) else $error("serial busy too short");
  chk_dat_busy_min: assert property (@(posedge clk) disable iff (!resetn)
    $rose(dbusy) |=> dbusy) else $error("data busy glitch");
  chk_host_quiet: assert property (@(posedge clk) disable iff (!resetn)
    dbusy [*8] |-> dat_h_oe == 4'h0) else $error("host drives data during busy");
  chk_cs_min_low: assert property (@(posedge clk) disable iff (!resetn)
    $fell(cs_n) |-> !cs_n [*8]) else $error("select pulse too short");
  cover property (@(posedge clk) $fell(sdo) && !cs_n);
  cover property (@(posedge clk) $rose(dbusy));
  cover property (@(posedge clk) $rose(cs_n));
endmodule : mcb_chk

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int BB = 8;
  logic        clk = 1'b0, card_clk = 1'b0, card_run = 1'b1, resetn = 1'b0;
  logic [1:0]  bus_mode = 2'h0, cmd_kind = 2'h0;
  logic        init_done = 1'b0, slow_clk = 1'b1, cmd_valid = 1'b0, wr_valid = 1'b0;
  logic [7:0]  wr_data = 8'h00, acc_cycles = 8'h00, prog_data;
  logic [31:0] acc_time = 32'h0;
  logic [5:0]  r2w_mult = 6'h01;
  logic        cmd_ready, wr_ready, done, timeout_err, prog_valid, prog_last, err, card_busy;
  logic        busy_seen = 1'b0;
  logic [7:0]  exp_q[$];
  int          failures = 0, num_checks = 0, cycles = 0, pcnt = 0, lat = 0;

  always #20 clk = ~clk;
  always begin
    #24;
    if (card_run) card_clk = ~card_clk;
  end

  mcb_if mcb_if_i ();
  mcb_host #(.BLOCK_BYTES(BB), .WR_TIMEOUT_CYC(200), .FIFO_DEPTH(8)) mcb_host_i (
    .clk(clk), .resetn(resetn), .bus_mode(bus_mode), .slow_clk(slow_clk),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_ready(cmd_ready),
    .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .read_access_time_field(acc_time), .access_clock_cycles_field(acc_cycles),
    .r2w_mult(r2w_mult), .done(done), .timeout_err(timeout_err),
    .link(mcb_if_i.host));
  mcb_card #(.BLOCK_BYTES(BB), .PROG_CYCLES(16)) mcb_card_i (
    .clk(card_clk), .resetn(resetn), .bus_mode(bus_mode), .init_done(init_done),
    .link(mcb_if_i.card), .prog_valid(prog_valid), .prog_data(prog_data),
    .prog_last(prog_last), .card_busy(card_busy));
  mcb_chk mcb_chk_i (
    .clk(clk), .resetn(resetn), .sclk(mcb_if_i.sclk), .cs_n(mcb_if_i.cs_n),
    .sdo(mcb_if_i.sdo), .sdo_c_oe(mcb_if_i.sdo_c_oe), .cmd_c_oe(mcb_if_i.cmd_c_oe),
    .dat_h_oe(mcb_if_i.dat_h_oe), .dat_c(mcb_if_i.dat_c), .dat_c_oe(mcb_if_i.dat_c_oe));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // ************
  // Monitors
  // ************
  always @(posedge card_clk) begin
    if (prog_valid) begin
      check(32'(prog_data), (exp_q.size() > 0) ? 32'(exp_q.pop_front()) : 32'h1FF);
      check(32'(prog_last), 32'((pcnt % BB) == BB - 1));
      check(32'(card_busy), 32'h1);
      pcnt++;
    end
  end
  always @(posedge clk) begin
    cycles++;
    if ((mcb_if_i.sdo_c_oe && !mcb_if_i.sdo_c) || (mcb_if_i.dat_c_oe[0] && !mcb_if_i.dat_c[0]))
      busy_seen <= 1'b1;
    if (cycles == 60000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic push_block(input logic [7:0] base);
    for (int i = 0; i < BB; i++) begin
      wr_valid <= 1'b1;
      wr_data <= base + 8'(i);
      exp_q.push_back(base + 8'(i));
      @(posedge clk);
      while (wr_ready !== 1'b1) @(posedge clk);
    end
    wr_valid <= 1'b0;
    @(posedge clk);
    check(32'(wr_ready), 32'h0);
  endtask : push_block

  task automatic run_cmd(input mcb_pkg::mcb_cmd_t kind);
    busy_seen = 1'b0;
    cmd_valid <= 1'b1;
    cmd_kind <= kind;
    @(posedge clk);
    while (cmd_ready !== 1'b1) @(posedge clk);
    cmd_valid <= 1'b0;
    lat = 0;
    do begin
      @(posedge clk);
      lat++;
    end while (done !== 1'b1 && lat < 20000);
    err = timeout_err;
    if (lat >= 20000) failures++;
  endtask : run_cmd

  // ************
  // Scenarios
  // ************
  task automatic t_slow_spi;
    push_block(8'h10);
    run_cmd(mcb_pkg::MCB_SINGLE);
    check(32'(err), 32'h0);
    check(32'(busy_seen), 32'h1);
    check(32'(exp_q.size()), 32'h0);
  endtask : t_slow_spi

  task automatic t_fast_modes;
    logic [1:0] modes [3];
    modes = '{mcb_pkg::MODE_SPI, mcb_pkg::MODE_NAT1, mcb_pkg::MODE_NAT4};
    init_done <= 1'b1;
    slow_clk <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      bus_mode <= modes[m];
      repeat (20) @(posedge clk);
      push_block(8'h20 + 8'(m * 16));
      run_cmd(mcb_pkg::MCB_SINGLE);
      check(32'(err), 32'h0);
      check(32'(busy_seen), 32'h1);
      check(32'(exp_q.size()), 32'h0);
    end
  endtask : t_fast_modes

  task automatic t_multi;
    run_cmd(mcb_pkg::MCB_STOP);
    check(32'(lat <= 2), 32'h1);
    for (int b = 0; b < 3; b++) begin
      push_block(8'h80 + 8'(b * 8));
      run_cmd(mcb_pkg::MCB_MULTI);
      check(32'(err), 32'h0);
      if (b == 0) check(32'(busy_seen), 32'h0);
    end
    run_cmd(mcb_pkg::MCB_STOP);
    check(32'(err), 32'h0);
    check(32'(exp_q.size()), 32'h0);
  endtask : t_multi

  task automatic t_timeout;
    bus_mode <= mcb_pkg::MODE_SPI;
    acc_time <= 32'h0000_00C8;
    acc_cycles <= 8'h01;
    r2w_mult <= 6'h02;
    card_run <= 1'b0;
    repeat (20) @(posedge clk);
    push_block(8'hC0);
    run_cmd(mcb_pkg::MCB_SINGLE);
    check(32'(err), 32'h1);
    check(32'(lat >= 600 && lat < 1200), 32'h1);
    card_run <= 1'b1;
    repeat (400) @(posedge clk);
    check(32'(exp_q.size()), 32'h0);
    check(32'(card_busy), 32'h0);
  endtask : t_timeout

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (300) @(posedge clk);
    t_slow_spi();
    t_fast_modes();
    t_multi();
    t_timeout();
    report_and_stop();
  end
endmodule : tb
